/* File: rtl/asr_sequencer.sv */
// Host-side sequencer that starts conversions and reads 16-bit serial results
// Operation
// - With external convert, shift only after busy line rises low to high.
// - Both peripheral selects stay high while other bus peripherals are used; bus_yield here only holds off a new transfer, one under way runs to its end.
// - Each processor-started conversion starts with an 8-bit transfer, both selects low.
// - Then a 16-bit transfer with only chip select low reads result.
// - Delay about 19 us after each transfer, then wrap queue to start.
// - Fastest setup: 4.19 MHz clock (reset divider of 5 gives 4.0 MHz), short delay, no select-to-clock delay.
// - Slow the rate by longer delay, never by slower shift clock.
// - Clock idles low; incoming data sampled on rising clock edge.
// - Command bytes are 20H for start and 61H for data transfer.
// - Upper result byte must be kept before lower byte overwrites it.
// - Gated clock, MSB first, 16-bit words, busy line as input.
// - Transmit and receive decoupled; start frame every second frame.
// - Processor-started arrangement reaches about 22 kHz conversion rate.
`default_nettype none
module asr_sequencer
   import asr_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic bus_yield,
   input wire logic serial_result_out,
   input wire logic parallel_msb_pin,
   input wire logic conv_busy_n,
   output logic result_shift_clock,
   output logic periph_select_zero_n,
   output logic periph_select_one_n,
   output logic res_valid,
   output logic [15:0] res_data,
   input wire logic res_ready
);
   logic [2:0] pin_meta_q;
   logic [2:0] pin_sync_q;
   logic busy_prev_q;
   logic busy_rise;
   logic sample_bit;
   logic en_q;
   logic self_q;
   logic msb_q;
   logic [15:0] delay_q;
   logic [7:0] half_q;
   logic [7:0] half_eff;
   logic ovr_q;
   logic [15:0] conv_cnt_q;
   logic [15:0] rdata_q;
   asr_state_e state_q;
   logic idx_q;
   asr_cmd_s cmd_next;
   asr_cmd_s cur_q;
   logic [7:0] half_cnt_q;
   logic [4:0] bit_cnt_q;
   logic [4:0] len_cur;
   logic sclk_q;
   logic [15:0] shreg_q;
   logic [15:0] dly_cnt_q;
   logic sel0_q;
   logic sel1_q;
   logic half_done;
   logic last_fall;
   logic push;
   logic pop;
   logic full;
   logic stall;
   logic start_ok;
   logic [15:0] mem_q [2];
   logic wp_q;
   logic rp_q;
   logic [1:0] cnt_q;

   // Pins from the converter are asynchronous to clk
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // Busy idles high; starting its stages high avoids a false end-of-conversion edge
         pin_meta_q <= 3'h4;
         pin_sync_q <= 3'h4;
         busy_prev_q <= 1'b1;
      end else begin
         pin_meta_q <= {conv_busy_n, parallel_msb_pin, serial_result_out};
         pin_sync_q <= pin_meta_q;
         busy_prev_q <= pin_sync_q[2];
      end
   end
   assign busy_rise = pin_sync_q[2] & ~busy_prev_q;
   // The MSB pin can be tri-stated, so other peripherals may share the input
   assign sample_bit = msb_q ? pin_sync_q[1] : pin_sync_q[0];

   assign half_eff = (half_q == 8'h00) ? 8'h01 : half_q;
   assign half_done = (half_cnt_q == 8'(half_eff - 8'h01));
   assign len_cur = cur_q.word ? LEN_WORD : LEN_BYTE;
   assign last_fall = (state_q == ST_SHIFT) && half_done && sclk_q
                      && (bit_cnt_q == 5'(len_cur - 5'h01));
   assign push = last_fall && cur_q.word;
   assign pop = res_valid && res_ready;
   assign full = (cnt_q == FIFO_DEPTH);
   // A new conversion is held back while no room is left for its result
   assign stall = en_q && self_q && !idx_q && full;
   assign start_ok = en_q && !bus_yield;
   // Queue of two commands; the start byte only every second frame
   assign cmd_next = asr_decode((self_q && !idx_q) ? CMD_START : CMD_READ);

   // Register file
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         en_q <= 1'b0;
         self_q <= 1'b0;
         msb_q <= 1'b0;
         delay_q <= DELAY_RST;
         half_q <= HALF_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            REG_CTRL: begin
               en_q <= reg_wdata[CTRL_EN];
               self_q <= reg_wdata[CTRL_SELF];
               msb_q <= reg_wdata[CTRL_MSB];
            end
            // Rate is set here by the gap, keeping the shift clock fast
            REG_DELAY: delay_q <= reg_wdata;
            REG_DIV: half_q <= reg_wdata[7:0];
            default: begin
            end
         endcase
      end
   end

   // Overrun: a result came in with the buffer full; set wins over clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ovr_q <= 1'b0;
      end else if (state_q == ST_WAIT && busy_rise && start_ok && full) begin
         ovr_q <= 1'b1;
      end else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STAT_OVR]) begin
         ovr_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         conv_cnt_q <= 16'h0000;
      end else if (push) begin
         conv_cnt_q <= 16'(conv_cnt_q + 16'h0001);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            REG_CTRL: rdata_q <= 16'({msb_q, self_q, en_q});
            REG_DELAY: rdata_q <= delay_q;
            REG_DIV: rdata_q <= {8'h00, half_q};
            REG_STATUS: rdata_q <= 16'({stall, ovr_q, full, res_valid,
                                        state_q != ST_IDLE});
            REG_RESULT: rdata_q <= res_data;
            REG_COUNT: rdata_q <= conv_cnt_q;
            default: rdata_q <= 16'h0000;
         endcase
      end else begin
         rdata_q <= 16'h0000;
      end
   end
   assign reg_rdata = rdata_q;

   // Transfer sequencer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         idx_q <= 1'b0;
         cur_q <= '0;
         sel0_q <= 1'b1;
         sel1_q <= 1'b1;
         half_cnt_q <= 8'h00;
         bit_cnt_q <= 5'h00;
         sclk_q <= 1'b0;
         dly_cnt_q <= 16'h0000;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (!en_q) begin
                  idx_q <= 1'b0;
               end else if (!self_q) begin
                  state_q <= ST_WAIT;
               end else if (start_ok && !stall) begin
                  cur_q <= cmd_next;
                  // Start byte pulls both selects low, read byte only chip select
                  sel0_q <= cmd_next.periph_select_zero;
                  sel1_q <= cmd_next.periph_select_one;
                  half_cnt_q <= 8'h00;
                  bit_cnt_q <= 5'h00;
                  state_q <= cmd_next.select_to_clock_delay_enable ? ST_LEAD : ST_SHIFT;
               end
            end
            ST_WAIT: begin
               if (!en_q || self_q) begin
                  state_q <= ST_IDLE;
               end else if (busy_rise && start_ok && !full) begin
                  cur_q <= cmd_next;
                  sel0_q <= cmd_next.periph_select_zero;
                  sel1_q <= cmd_next.periph_select_one;
                  half_cnt_q <= 8'h00;
                  bit_cnt_q <= 5'h00;
                  state_q <= cmd_next.select_to_clock_delay_enable ? ST_LEAD : ST_SHIFT;
               end
            end
            ST_LEAD: begin
               if (half_done) begin
                  half_cnt_q <= 8'h00;
                  state_q <= ST_SHIFT;
               end else begin
                  half_cnt_q <= 8'(half_cnt_q + 8'h01);
               end
            end
            ST_SHIFT: begin
               if (!half_done) begin
                  half_cnt_q <= 8'(half_cnt_q + 8'h01);
               end else begin
                  half_cnt_q <= 8'h00;
                  sclk_q <= ~sclk_q;
                  if (last_fall) begin
                     // Convert select is low only for the 8 start clocks
                     sel0_q <= 1'b1;
                     sel1_q <= 1'b1;
                     dly_cnt_q <= delay_q;
                     state_q <= ST_DELAY;
                  end else if (sclk_q) begin
                     bit_cnt_q <= 5'(bit_cnt_q + 5'h01);
                  end
               end
            end
            ST_DELAY: begin
               if (!cur_q.dt || dly_cnt_q <= 16'h0001) begin
                  dly_cnt_q <= 16'h0000;
                  if (self_q) begin
                     idx_q <= ~idx_q;
                     state_q <= ST_IDLE;
                  end else begin
                     state_q <= ST_WAIT;
                  end
               end else begin
                  dly_cnt_q <= 16'(dly_cnt_q - 16'h0001);
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Sample on the rising edge of the shift clock, MSB first
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shreg_q <= 16'h0000;
      end else if (state_q == ST_SHIFT && half_done && !sclk_q) begin
         shreg_q <= {shreg_q[14:0], sample_bit};
      end
   end

   assign result_shift_clock = sclk_q;
   assign periph_select_zero_n = sel0_q;
   assign periph_select_one_n = sel1_q;

   // Two-entry result buffer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
         mem_q[0] <= 16'h0000;
         mem_q[1] <= 16'h0000;
      end else begin
         if (push) begin
            mem_q[wp_q] <= shreg_q;
            wp_q <= ~wp_q;
         end
         if (pop) begin
            rp_q <= ~rp_q;
         end
         if (push && !pop) begin
            cnt_q <= 2'(cnt_q + 2'h1);
         end else if (pop && !push) begin
            cnt_q <= 2'(cnt_q - 2'h1);
         end
      end
   end
   assign res_valid = (cnt_q != 2'h0);
   assign res_data = mem_q[rp_q];

   AST_SEL_IDLE_HIGH: assert property (@(posedge clk) disable iff (rst)
      (state_q inside {ST_IDLE, ST_WAIT, ST_DELAY}) |->
         (periph_select_zero_n && periph_select_one_n))
      else $error("select low outside a transfer");

   AST_CONVERT_ONLY_START: assert property (@(posedge clk) disable iff (rst)
      !periph_select_zero_n |-> (!periph_select_one_n && !cur_q.word && self_q))
      else $error("convert select low outside the start transfer");

   AST_READ_CS_ONLY: assert property (@(posedge clk) disable iff (rst)
      (state_q == ST_SHIFT && cur_q.word) |->
         (periph_select_zero_n && !periph_select_one_n))
      else $error("read transfer selects wrong");

   AST_DELAY_LOAD: assert property (@(posedge clk) disable iff (rst)
      last_fall |=> (state_q == ST_DELAY && dly_cnt_q == $past(delay_q)))
      else $error("delay not loaded after transfer");

   AST_WRAP: assert property (@(posedge clk) disable iff (rst)
      (state_q == ST_DELAY && self_q && idx_q) ##1 (state_q == ST_IDLE) |-> !idx_q)
      else $error("queue did not wrap");

   AST_NO_START_YIELD: assert property (@(posedge clk) disable iff (rst)
      (bus_yield && state_q inside {ST_IDLE, ST_WAIT}) |=> !(state_q inside {ST_LEAD, ST_SHIFT}))
      else $error("transfer started while the bus was lent");

   AST_STALL_HOLD: assert property (@(posedge clk) disable iff (rst)
      (stall && state_q == ST_IDLE) |=> (state_q == ST_IDLE))
      else $error("conversion started with the result buffer full");

   AST_SCLK_IDLE_LOW: assert property (@(posedge clk) disable iff (rst)
      (state_q != ST_SHIFT) |-> !result_shift_clock)
      else $error("shift clock not low while idle");

   AST_SAMPLE_ON_RISE: assert property (@(posedge clk) disable iff (rst)
      $changed(shreg_q) |-> $rose(sclk_q))
      else $error("data captured off the rising edge");

   AST_EXT_AFTER_BUSY: assert property (@(posedge clk) disable iff (rst)
      ($past(state_q) == ST_WAIT && state_q == ST_SHIFT) |-> $past(busy_rise))
      else $error("shift started without busy rise");

   AST_PUSH_WORD: assert property (@(posedge clk) disable iff (rst)
      push |-> (cur_q.word && bit_cnt_q == 5'(LEN_WORD - 5'h01) && !full))
      else $error("result pushed at wrong point or into full buffer");

   AST_CLOCK_COUNT: assert property (@(posedge clk) disable iff (rst)
      last_fall |-> (bit_cnt_q == 5'(len_cur - 5'h01)) ##1 !result_shift_clock)
      else $error("transfer length wrong");
endmodule // asr_sequencer
`default_nettype wire

/* File: shared/asr_pkg.sv */
// Constants, command layout and types for the converter readout sequencer
`default_nettype none
package asr_pkg;
   localparam int CLK_NS = 25;
   localparam int CLK_KHZ = 40000;
   localparam int SCLK_KHZ = 4190;
   localparam int DELAY_NS = 19000;
   // Rounded up so the shift clock never runs faster than its target
   localparam logic [7:0] HALF_RST = 8'((CLK_KHZ + 2 * SCLK_KHZ - 1) / (2 * SCLK_KHZ));
   localparam logic [15:0] DELAY_RST = 16'((DELAY_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] CMD_START = 8'h20;
   localparam logic [7:0] CMD_READ = 8'h61;
   localparam int CMDB_WORD = 6;
   localparam int CMDB_DT = 5;
   localparam int CMDB_SELECT_TO_CLOCK_DELAY_ENABLE = 4;
   localparam int CMDB_PERIPH_SELECT_ONE = 1;
   localparam int CMDB_PERIPH_SELECT_ZERO = 0;
   localparam logic [4:0] LEN_BYTE = 5'h08;
   localparam logic [4:0] LEN_WORD = 5'h10;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_DELAY = 4'h1;
   localparam logic [3:0] REG_DIV = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_RESULT = 4'h4;
   localparam logic [3:0] REG_COUNT = 4'h5;
   localparam int CTRL_EN = 0;
   localparam int CTRL_SELF = 1;
   localparam int CTRL_MSB = 2;
   localparam int STAT_ACTIVE = 0;
   localparam int STAT_AVAIL = 1;
   localparam int STAT_FULL = 2;
   localparam int STAT_OVR = 3;
   localparam int STAT_STALL = 4;
   localparam logic [1:0] FIFO_DEPTH = 2'h2;
   typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_LEAD, ST_SHIFT, ST_DELAY} asr_state_e;
   typedef struct packed {
      logic word;
      logic dt;
      logic select_to_clock_delay_enable;
      logic periph_select_one;
      logic periph_select_zero;
   } asr_cmd_s;
   function automatic asr_cmd_s asr_decode(input logic [7:0] b);
      asr_cmd_s c;
      c.word = b[CMDB_WORD];
      c.dt = b[CMDB_DT];
      c.select_to_clock_delay_enable = b[CMDB_SELECT_TO_CLOCK_DELAY_ENABLE];
      c.periph_select_one = b[CMDB_PERIPH_SELECT_ONE];
      c.periph_select_zero = b[CMDB_PERIPH_SELECT_ZERO];
      return c;
   endfunction
endpackage
`default_nettype wire

/* File: verif/asr_conv_model.sv */
// Behavioural converter on the far side of the readout sequencer
`default_nettype none
module asr_conv_model #(
   parameter int CONV_NS = 1500
) (
   input wire logic result_shift_clock,
   input wire logic periph_select_zero_n,
   input wire logic periph_select_one_n,
   input wire logic ext_convert,
   output logic conv_busy_n,
   output logic serial_result_out,
   output logic parallel_msb_pin,
   output int n_frames,
   output int frame_bits,
   output logic frame_read
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] word_q;
   logic [15:0] sh;
   logic out_q;
   int n_conv;
   wire logic go = ext_convert | (~periph_select_zero_n & ~periph_select_one_n);
   assign serial_result_out = out_q;
   // Unselected pin floats: shows a toggling value, never a stale bit
   assign parallel_msb_pin = out_q;
   initial begin
      conv_busy_n = 1'b1;
      out_q = 1'b0;
      word_q = 16'h0000;
      n_conv = 0;
      n_frames = 0;
      frame_bits = 0;
      frame_read = 1'b0;
   end
   always @(posedge go) begin
      conv_busy_n = 1'b0;
      #(CONV_NS);
      word_q = 16'h3A5C ^ 16'(n_conv * 16'h1F1F);
      n_conv++;
      conv_busy_n = 1'b1;
   end
   always begin
      @(negedge periph_select_one_n);
      // Let both select registers settle before judging the frame kind
      #1;
      sh = word_q;
      frame_read = periph_select_zero_n;
      frame_bits = 0;
      while (!periph_select_one_n) begin
         out_q = frame_read ? sh[15] : ~out_q;
         @(posedge result_shift_clock or posedge periph_select_one_n);
         if (!periph_select_one_n) frame_bits++;
         @(negedge result_shift_clock or posedge periph_select_one_n);
         sh = sh << 1;
      end
      out_q = ~out_q;
      n_frames++;
   end
endmodule // asr_conv_model
`default_nettype wire

/* File: verif/tb_asr_sequencer.sv */
// Self-checking bench for the converter readout sequencer
`default_nettype none
module tb_asr_sequencer import asr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, reg_wr, reg_rd, bus_yield, res_ready, ext_convert;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, res_data, rv;
   logic sdo, msb, busy_n, sclk, sel0_n, sel1_n, res_valid, frd;
   int failures = 0, n_checks = 0, nf, fb, nf0, k = 0, dly = 760;
   realtime t_rel = 0;
   realtime t_rise = 0;
   logic frd_prev = 1'b1;
   bit self_on = 1'b0;

   asr_sequencer DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_yield(bus_yield),
      .serial_result_out(sdo), .parallel_msb_pin(msb), .conv_busy_n(busy_n),
      .result_shift_clock(sclk), .periph_select_zero_n(sel0_n),
      .periph_select_one_n(sel1_n), .res_valid(res_valid), .res_data(res_data),
      .res_ready(res_ready));
   asr_conv_model conv (.result_shift_clock(sclk), .periph_select_zero_n(sel0_n),
      .periph_select_one_n(sel1_n), .ext_convert(ext_convert), .conv_busy_n(busy_n),
      .serial_result_out(sdo), .parallel_msb_pin(msb), .n_frames(nf),
      .frame_bits(fb), .frame_read(frd));

   task automatic final_report;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   function automatic logic [15:0] ew(input int n);
      return 16'h3A5C ^ 16'(n * 16'h1F1F);
   endfunction
   task automatic pop(input string what);
      // Let the edge that ended the caller settle before looking at the head
      #1;
      for (int i = 0; i < 3000 && res_valid !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk(what, ew(k), res_data);
      k++;
      @(posedge clk);
      res_ready <= 1'b1;
      @(posedge clk);
      res_ready <= 1'b0;
   endtask
   task automatic cvt;
      @(posedge clk);
      ext_convert <= 1'b1;
      repeat (4) @(posedge clk);
      ext_convert <= 1'b0;
   endtask

   task automatic t_reset;
      rd(REG_DELAY);
      chk("delay reset", 16'h02F8, rv);
      rd(REG_DIV);
      chk("div reset", 16'h0005, rv);
      rd(REG_CTRL);
      chk("ctrl reset", 16'h0000, rv);
      wr(4'hF, 16'hFFFF);
      rd(4'hF);
      chk("unmapped", 16'h0000, rv);
      chk("selects idle", 16'h0003, {14'h0, sel0_n, sel1_n});
   endtask
   task automatic t_ext;
      dly = 4;
      wr(REG_DELAY, 16'h0004);
      wr(REG_CTRL, 16'h0001);
      cvt;
      pop("ext word");
      chk("ext frame kind", 16'h0001, {15'h0, frd});
      @(posedge clk);
      bus_yield <= 1'b1;
      nf0 = nf;
      cvt;
      repeat (200) @(posedge clk);
      chk("frames in yield", 16'(nf0), 16'(nf));
      k++;
      bus_yield <= 1'b0;
      cvt;
      pop("word after yield");
      wr(REG_CTRL, 16'h0000);
      repeat (20) @(posedge clk);
   endtask
   task automatic t_self;
      self_on = 1'b1;
      wr(REG_CTRL, 16'h0007);
      pop("self word 0");
      pop("self word 1");
   endtask
   task automatic t_full;
      // Consumer stalls: the third start must wait, no word may be lost
      repeat (1200) @(posedge clk);
      rd(REG_STATUS);
      chk("full status", 16'h0016, rv & 16'h0016);
      pop("stalled word 0");
      pop("stalled word 1");
      pop("resumed word");
      rd(REG_COUNT);
      chk("push count", 16'h0007, rv);
   endtask

   always @(nf) begin
      if (nf > 0) chk("frame bits", frd ? 16'h0010 : 16'h0008, 16'(fb));
      if (self_on) chk("frame order", {15'h0, ~frd_prev}, {15'h0, frd});
      frd_prev = frd;
   end
   always @(posedge sel1_n) t_rel = $realtime;
   always @(negedge sel1_n) begin
      if (t_rel > 0) chk("gap", 16'h0001, {15'h0, ($realtime - t_rel) >= dly * 25.0});
   end
   // The rate is set by the gap alone: the shift clock keeps its half period
   always @(posedge sclk) t_rise = $realtime;
   always @(negedge sclk) begin
      if (t_rise > 0) begin
         chk("half period", 16'(HALF_RST), 16'(int'(($realtime - t_rise) / 25.0)));
      end
   end
   always @(posedge clk) if (sel1_n === 1'b1) chk("clock idle", 16'h0000, {15'h0, sclk});

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #1000000;
      failures++;
      final_report;
   end
   initial begin
      rst = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      bus_yield = 1'b0;
      res_ready = 1'b0;
      ext_convert = 1'b0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_ext;
      t_self;
      t_full;
      final_report;
   end
endmodule // tb_asr_sequencer
`default_nettype wire
